// file: hdl/iprc_consts.vh
`ifndef IPRC_CONSTS_VH
`define IPRC_CONSTS_VH
// register byte addresses (offsets chosen locally, one aligned word each)
`define IPRC_ADC_UART_OFFSET     12'h000
`define IPRC_CHG_CMP_I2C_OFFSET  12'h004
// field positions (low bit of each 3-bit field)
`define IPRC_CONV_DONE_LSB       4
`define IPRC_SERIAL_TX_LSB       0
`define IPRC_PIN_CHANGE_LSB      12
`define IPRC_COMPARATOR_LSB      8
`define IPRC_I2C_MASTER_LSB      4
`define IPRC_I2C_SLAVE_LSB       0
// field reset value and special codes
`define IPRC_FIELD_RESET         3'h4
`define IPRC_FIELD_DISABLED      3'h0
// writable masks of the two registers
`define IPRC_ADC_UART_MASK       16'h0077
`define IPRC_CHG_CMP_I2C_MASK    16'h7777
`endif

// file: hdl/iprc_field.v
`timescale 1ns/100ps
`include "iprc_consts.vh"
// one 3-bit priority field with its decoded level and enable
module iprc_field (
    input  wire       clk,     // system clock
    input  wire       rst,     // async reset, active high
    input  wire       wr_en,   // write strobe for this field
    input  wire [2:0] wr_data, // new field value
    output reg  [2:0] level,   // stored priority level
    output reg        enabled  // source may request
);
    // load priority level four at power-on
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            level   <= `IPRC_FIELD_RESET;     // see (R9)
            enabled <= 1'b1;
        end else if (wr_en) begin
            level   <= wr_data;               // see (R1) (R2)
            enabled <= (wr_data != `IPRC_FIELD_DISABLED); // see (R3)
        end
    end
endmodule

// file: hdl/iprc_regs.v
// The AHB-Lite slave port and the address map are this design's own decisions.
`timescale 1ns/100ps
`include "iprc_consts.vh"
// Functional notes
// (R1) Field code 111 means priority level seven, the highest.
// (R2) Field code 001 means level one, codes 010..110 map linearly to levels two to six.
// (R3) Field code 000 disables the source so it never requests an interrupt.
// (R4) First register bits 6:4 hold the conversion-done priority, read/write.
// (R5) First register bits 2:0 hold the serial transmit priority, read/write.
// (R6) Second register bits 14:12 hold the pin-change priority, read/write.
// (R7) Second register bits 10:8 hold the comparator priority, read/write.
// (R8) Unimplemented bits read as zero and ignore writes.
// (R9) Reset loads every field with 100; second register 6:4 is i2c master, 2:0 i2c slave.
module iprc_regs (
    input  wire        clk,                   // system clock
    input  wire        rst,                   // async reset, active high
    input  wire        hsel,                  // slave select
    input  wire [11:0] haddr,                 // byte address
    input  wire [1:0]  htrans,                // transfer type
    input  wire        hwrite,                // write when high
    input  wire [2:0]  hsize,                 // transfer size
    input  wire [31:0] hwdata,                // write data
    input  wire        hready,                // bus ready in
    output reg  [31:0] hrdata,                // read data
    output reg         hreadyout,             // always ready
    output reg         hresp,                 // always okay
    output reg  [2:0]  conv_done_priority,    // conversion-done level
    output reg  [2:0]  serial_tx_priority,    // serial transmit level
    output reg  [2:0]  pin_change_priority,   // pin-change level
    output reg  [2:0]  comparator_priority,   // comparator level
    output reg  [2:0]  i2c_master_priority,   // i2c master level
    output reg  [2:0]  i2c_slave_priority,    // i2c slave level
    output reg  [5:0]  source_enable          // per-source enable, order as above
);
    localparam NFIELD = 6;

    reg         wr_pend;   // write address phase captured
    reg  [11:0] wr_addr;   // captured write address
    wire [2:0]  lvl [0:NFIELD-1];
    wire [NFIELD-1:0] en;
    wire [NFIELD-1:0] fwe;
    wire [2:0]  fdat [0:NFIELD-1];
    wire        sel_a;
    wire        sel_b;
    wire [15:0] reg_a;
    wire [15:0] reg_b;
    wire        rd_req;

    // decode the data phase of a captured write
    assign sel_a  = wr_pend && (wr_addr == `IPRC_ADC_UART_OFFSET);
    assign sel_b  = wr_pend && (wr_addr == `IPRC_CHG_CMP_I2C_OFFSET);
    assign rd_req = hsel && hready && htrans[1] && !hwrite;

    // field write strobes and data; only implemented bits are taken
    assign fwe[0] = sel_a;                                          // see (R4)
    assign fdat[0] = hwdata[`IPRC_CONV_DONE_LSB +: 3];               // see (R4)
    assign fwe[1] = sel_a;                                          // see (R5)
    assign fdat[1] = hwdata[`IPRC_SERIAL_TX_LSB +: 3];               // see (R5)
    assign fwe[2] = sel_b;                                          // see (R6)
    assign fdat[2] = hwdata[`IPRC_PIN_CHANGE_LSB +: 3];              // see (R6)
    assign fwe[3] = sel_b;                                          // see (R7)
    assign fdat[3] = hwdata[`IPRC_COMPARATOR_LSB +: 3];              // see (R7)
    assign fwe[4] = sel_b;                                          // see (R9)
    assign fdat[4] = hwdata[`IPRC_I2C_MASTER_LSB +: 3];              // see (R9)
    assign fwe[5] = sel_b;                                          // see (R9)
    assign fdat[5] = hwdata[`IPRC_I2C_SLAVE_LSB +: 3];               // see (R9)

    genvar gi;
    generate
        for (gi = 0; gi < NFIELD; gi = gi + 1) begin : g_fld
            iprc_field u_fld (
                .clk     (clk),
                .rst     (rst),
                .wr_en   (fwe[gi]),
                .wr_data (fdat[gi]),
                .level   (lvl[gi]),
                .enabled (en[gi])
            );
        end
    endgenerate

    // assemble read images, unimplemented bits forced to zero
    assign reg_a = ({9'h000, lvl[0], 1'b0, lvl[1]}) & `IPRC_ADC_UART_MASK;      // see (R8)
    assign reg_b = ({1'b0, lvl[2], 1'b0, lvl[3], 1'b0, lvl[4], 1'b0, lvl[5]})
                   & `IPRC_CHG_CMP_I2C_MASK;                                     // see (R8)

    // capture write address phase; zero-wait slave so hready is never low from us
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            wr_pend <= 1'b0;
            wr_addr <= 12'h000;
        end else if (hready) begin
            wr_pend <= hsel && htrans[1] && hwrite;
            wr_addr <= haddr;
        end
    end

    // read data registered at the address phase edge, stands in the data phase
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            hrdata    <= 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            if (rd_req) begin
                if (haddr == `IPRC_ADC_UART_OFFSET)
                    hrdata <= {16'h0000, reg_a};                // see (R4) (R5) (R8)
                else if (haddr == `IPRC_CHG_CMP_I2C_OFFSET)
                    hrdata <= {16'h0000, reg_b};                // see (R6) (R7) (R8)
                else
                    hrdata <= 32'h0000_0000;                    // unmapped reads zero
            end
        end
    end

    // outputs to the arbiter, registered so they come straight from flops
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            conv_done_priority  <= `IPRC_FIELD_RESET;
            serial_tx_priority  <= `IPRC_FIELD_RESET;
            pin_change_priority <= `IPRC_FIELD_RESET;
            comparator_priority <= `IPRC_FIELD_RESET;
            i2c_master_priority <= `IPRC_FIELD_RESET;
            i2c_slave_priority  <= `IPRC_FIELD_RESET;
            source_enable       <= 6'h3f;
        end else begin
            conv_done_priority  <= lvl[0];                      // see (R1) (R2)
            serial_tx_priority  <= lvl[1];
            pin_change_priority <= lvl[2];
            comparator_priority <= lvl[3];
            i2c_master_priority <= lvl[4];
            i2c_slave_priority  <= lvl[5];
            source_enable       <= en;                          // see (R3)
        end
    end
endmodule

// file: verification/iprc_regs_properties.sv
`timescale 1ns/100ps
`include "iprc_consts.vh"
module iprc_regs_chk (
    input wire        clk, rst, hsel, hwrite, hready, hreadyout, hresp, // bus control
    input wire [11:0] haddr,                                           // byte address
    input wire [1:0]  htrans,                                          // transfer type
    input wire [31:0] hwdata, hrdata,                                  // data buses
    input wire [2:0]  conv_done_priority, serial_tx_priority,          // first register
    input wire [2:0]  pin_change_priority, comparator_priority,        // second, high
    input wire [2:0]  i2c_master_priority, i2c_slave_priority,         // second, low
    input wire [5:0]  source_enable                                    // nonzero fields
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // address phases the slave takes, split by kind
    wire take = hsel && hready && htrans[1];
    wire rd0  = take && !hwrite && haddr == `IPRC_ADC_UART_OFFSET;
    wire rd1  = take && !hwrite && haddr == `IPRC_CHG_CMP_I2C_OFFSET;
    wire rdx  = take && !hwrite && haddr > `IPRC_CHG_CMP_I2C_OFFSET;
    wire wr0  = take && hwrite && haddr == `IPRC_ADC_UART_OFFSET;
    chk_bus_okay: assert property (hreadyout && !hresp) else $error("bus answer wrong");
    chk_rd_first: assert property (rd0 |=> hrdata ==
        {25'h0, conv_done_priority, 1'b0, serial_tx_priority}) else $error("first read");
    chk_rd_second: assert property (rd1 |=> hrdata == {17'h0,
        pin_change_priority, 1'b0, comparator_priority, 1'b0, i2c_master_priority,
        1'b0, i2c_slave_priority}) else $error("second read");
    chk_rd_unmapped: assert property (rdx |=> hrdata == 32'h0) else $error("bad read");
    // field lands at the end of the data phase, the level outputs one edge later
    chk_wr_lands: assert property (wr0 ##2 1 |=> conv_done_priority ==
        $past(hwdata[6:4], 2) && serial_tx_priority == $past(hwdata[2:0], 2))
        else $error("write");
    chk_level_hold: assert property (!$past(wr0, 3) |->
        $stable({conv_done_priority, serial_tx_priority})) else $error("level moved");
    chk_en_low: assert property (source_enable[1:0] ==
        {serial_tx_priority != 0, conv_done_priority != 0}) else $error("enable low");
    chk_en_high: assert property (source_enable[5:2] == {i2c_slave_priority != 0,
        i2c_master_priority != 0, comparator_priority != 0, pin_change_priority != 0})
        else $error("enable high");
    chk_reset_load: assert property ($fell(rst) |-> {conv_done_priority,
        serial_tx_priority, pin_change_priority, comparator_priority, i2c_master_priority,
        i2c_slave_priority} == {6{3'h4}}) else $error("reset value");
    cover property (wr0 ##3 conv_done_priority == 3'h7);
    cover property (rd1 ##1 source_enable[5:2] == 4'h0);
    cover property (rdx);
endmodule
bind iprc_regs iprc_regs_chk u_chk (
    .clk                 (clk),
    .rst                 (rst),
    .hsel                (hsel),
    .hwrite              (hwrite),
    .hready              (hready),
    .hreadyout           (hreadyout),
    .hresp               (hresp),
    .haddr               (haddr),
    .htrans              (htrans),
    .hwdata              (hwdata),
    .hrdata              (hrdata),
    .conv_done_priority  (conv_done_priority),
    .serial_tx_priority  (serial_tx_priority),
    .pin_change_priority (pin_change_priority),
    .comparator_priority (comparator_priority),
    .i2c_master_priority (i2c_master_priority),
    .i2c_slave_priority  (i2c_slave_priority),
    .source_enable       (source_enable)
);

// file: verification/interrupt_priority_regs_tb_top.sv
`timescale 1ns/100ps
module interrupt_priority_regs_tb_top;
    reg         clk = 0, rst = 1, hsel = 0, hwrite = 0;
    reg  [11:0] haddr = 0;
    reg  [1:0]  htrans = 0;
    reg  [31:0] hwdata = 0;
    wire [31:0] hrdata;
    wire        hreadyout, hresp;
    wire [2:0]  cd, st, pc, cp, im, sl;
    wire [5:0]  en;
    int         n_mismatch = 0, compares = 0, cyc = 0;
    // single slave, so its ready is the bus ready; size is always a word
    iprc_regs u_dut (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .conv_done_priority(cd), .serial_tx_priority(st),
        .pin_change_priority(pc), .comparator_priority(cp), .i2c_master_priority(im),
        .i2c_slave_priority(sl), .source_enable(en));
    always #10 clk = ~clk;
    // a hang is cut short well past the fewer than a hundred cycles the run needs
    always @(posedge clk) if (++cyc > 3000) begin n_mismatch++; report_and_stop; end
    task automatic chk(input string n, input [31:0] e, input [31:0] s);
        compares++;
        if (s !== e) begin
            $display("CHECK FAILED %s expected %h seen %h", n, e, s);
            n_mismatch++;
        end
    endtask
    // one word transfer; zero wait states are promised, but ready is still polled
    task automatic xfer(input w, input [11:0] a, input [31:0] d);
        @(posedge clk);
        hsel <= 1; htrans <= 2'b10; hwrite <= w; haddr <= a;
        do @(posedge clk); while (hreadyout !== 1'b1);
        hsel <= 0; htrans <= 2'b00; hwdata <= d;
        do @(posedge clk); while (hreadyout !== 1'b1);
    endtask
    task automatic rd(input [11:0] a, input [31:0] e);
        xfer(0, a, 32'h0);
        chk("hrdata", e, hrdata);
    endtask
    task t_reset;
        rd(12'h000, 32'h44);
        rd(12'h004, 32'h4444);
        chk("levels", {8'h0, {6{3'h4}}, 6'h3f}, {8'h0, cd, st, pc, cp, im, sl, en});
    endtask
    // every code in both first fields, junk aimed at the unimplemented bits
    task t_codes;
        for (int k = 0; k < 8; k++) begin
            xfer(1, 12'h000, 32'hffffff88 | (k << 4) | k);
            rd(12'h000, (k << 4) | k);
            chk("first", {3'(k), 3'(k), {2{k != 0}}}, {cd, st, en[1:0]});
        end
    endtask
    task t_second;
        xfer(1, 12'h004, 32'hffffffff);
        rd(12'h004, 32'h7777);
        xfer(1, 12'h004, 32'h00007531);
        rd(12'h004, 32'h7531);
        chk("second", {3'h7, 3'h5, 3'h3, 3'h1}, {pc, cp, im, sl});
        xfer(1, 12'h004, 32'h0);
        // enables follow the field one edge later, so let two edges pass
        repeat (2) @(posedge clk);
        chk("enables", 4'h0, en[5:2]);
    endtask
    // unmapped writes vanish and must not leak into the real registers
    task t_unmapped;
        xfer(1, 12'h008, 32'hffffffff);
        rd(12'h008, 32'h0);
        rd(12'h000, 32'h77);
        rd(12'h004, 32'h0);
    endtask
    task report_and_stop;
        if (n_mismatch == 0 && compares > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    initial begin
        repeat (3) @(posedge clk);
        rst <= 0;
        t_reset;
        t_codes;
        t_second;
        t_unmapped;
        report_and_stop;
    end
endmodule
